// ### hdl/ssf_port.sv
// frame sequencer for the synchronous serial port, master or slave
`timescale 1ns/10ps
`include "ssf_consts.svh"
module ssf_port #(
    parameter logic [7:0] HALF_CYCLES = `SSF_HALF_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic enable,
    input wire logic is_master,
    input wire logic clock_polarity_bit,
    input wire logic clock_phase_bit,
    input wire logic [1:0] frame_format_field,
    input wire logic [3:0] word_size_field,
    input wire logic tx_valid,
    input wire logic [15:0] tx_data,
    output logic tx_ready,
    output logic rx_valid,
    output logic [15:0] rx_data,
    output logic busy,
    input wire logic port_serial_clock_in,
    output logic port_serial_clock_out,
    output logic port_serial_clock_oe,
    input wire logic frame_select_line_in,
    output logic frame_select_line_out,
    output logic frame_select_line_oe,
    output logic serial_out_line,
    output logic serial_out_line_oe,
    input wire logic serial_in_line
);
    import ssf_pkg::*;

    localparam ssf_regs_type RST = '{
        st: SSF_IDLE, div: 8'h00, sclk: 1'b0, fss: 1'b1, drive: 1'b0, sout: 1'b0,
        kcnt: 6'h00, tx_sh: 16'h0000, rx_sh: 16'h0000, pend: 1'b0, sclk_prev: 1'b0,
        rx_valid: 1'b0, rx_data: 16'h0000
    };

    ssf_regs_type r;
    ssf_regs_type n;
    logic [2:0] pins_s;
    logic sclk_s;
    logic fss_s;
    logic sin_s;
    logic half_fmt;
    logic spi_fmt;
    logic cpol;
    logic [4:0] nbits;
    logic size_ok;
    logic tick;
    logic edge_now;
    logic load;
    logic [2:0] role;
    logic [5:0] k;

    // pins cross into the system clock before anything looks at them
    ssf_sync #(.W(3)) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ce(ce),
        .d_in({port_serial_clock_in, frame_select_line_in, serial_in_line}),
        .q_out(pins_s)
    );

    assign sclk_s = pins_s[2];
    assign fss_s = pins_s[1];
    assign sin_s = pins_s[0];

    // role of clock edge k in a frame: {sample, shift, last sample}
    function automatic logic [2:0] edge_role(input logic hd, input logic ph, input logic slv,
                                             input logic [5:0] kk, input logic [4:0] nb);
        logic [5:0] twice;
        logic smp;
        logic shf;
        logic lst;
        twice = {nb, 1'b0};
        smp = kk[0];
        shf = !kk[0];
        lst = (kk == twice - 6'h01);
        if (hd && !slv) begin
            shf = !kk[0] && (kk <= `SSF_CTRL_EDGES);
            smp = kk[0] && (kk > `SSF_REPLY_BASE);
            lst = (kk == `SSF_REPLY_BASE + twice);
        end else if (!hd && ph) begin
            smp = !kk[0];
            shf = kk[0] && (kk != 6'h01);
            lst = (kk == twice);
        end
        return {smp, shf, lst};
    endfunction

    function automatic logic [15:0] align_word(input logic [15:0] d, input logic [4:0] nb);
        logic [4:0] sh;
        sh = 5'h10 - nb;
        return d << sh;
    endfunction

    always_comb begin
        half_fmt = (frame_format_field == `SSF_FMT_HALF);
        spi_fmt = (frame_format_field == `SSF_FMT_SPI);
        cpol = clock_polarity_bit && !half_fmt;
        nbits = {1'b0, word_size_field} + 5'h01;
        size_ok = (word_size_field >= `SSF_SIZE_MIN);
        tick = (r.div == HALF_CYCLES - 8'h01);
        n = r;
        n.rx_valid = 1'b0;
        n.sclk_prev = sclk_s;
        n.div = tick ? 8'h00 : r.div + 8'h01;
        load = 1'b0;
        edge_now = 1'b0;
        role = 3'b000;
        k = r.kcnt + 6'h01;
        unique case (r.st)
            SSF_IDLE: begin
                n.sclk = cpol;
                n.fss = 1'b1;
                n.drive = 1'b0;
                n.kcnt = 6'h00;
                n.pend = 1'b0;
                if (enable && size_ok && (spi_fmt || half_fmt)) begin
                    if (is_master && tick && tx_valid) begin
                        load = 1'b1;
                        n.fss = 1'b0;
                        n.st = SSF_SETUP;
                        n.drive = half_fmt;
                        n.rx_sh = 16'h0000;
                    end else if (!is_master && !fss_s) begin
                        load = 1'b1;
                        n.st = SSF_XFER;
                        n.drive = !clock_phase_bit || half_fmt;
                        n.rx_sh = 16'h0000;
                    end
                end
            end
            SSF_SETUP: begin
                if (tick) begin
                    if (r.sclk != cpol) begin
                        n.sclk = cpol;
                        n.rx_valid = r.pend;
                        n.rx_data = r.rx_sh;
                        n.pend = 1'b0;
                        n.rx_sh = 16'h0000;
                    end else if (spi_fmt && !clock_phase_bit && !r.drive) begin
                        n.drive = 1'b1;
                    end else begin
                        n.st = SSF_XFER;
                        edge_now = 1'b1;
                    end
                end
            end
            SSF_XFER: begin
                if (is_master) begin
                    edge_now = tick;
                end else begin
                    edge_now = (sclk_s != r.sclk_prev);
                end
            end
            SSF_TAIL: begin
                if (tick) begin
                    n.sclk = cpol;
                    n.kcnt = r.kcnt + 6'h01;
                    if (r.kcnt == `SSF_TAIL_LAST) begin
                        n.fss = 1'b1;
                        n.st = SSF_IDLE;
                        n.drive = 1'b0;
                        n.div = 8'h00;
                        n.rx_valid = r.pend;
                        n.rx_data = r.rx_sh;
                        n.pend = 1'b0;
                    end
                end
            end
        endcase

        if (edge_now) begin
            n.kcnt = k;
            if (is_master) begin
                n.sclk = !r.sclk;
            end
            role = edge_role(half_fmt, clock_phase_bit, !is_master, k, nbits);
            if (spi_fmt && clock_phase_bit && k == 6'h01) begin
                n.drive = 1'b1;
            end
            if (role[1]) begin
                n.tx_sh = {r.tx_sh[14:0], 1'b0};
            end
            if (role[2]) begin
                n.rx_sh = {r.rx_sh[14:0], sin_s};
            end
            if (role[0]) begin
                n.kcnt = 6'h00;
                if (!is_master) begin
                    n.rx_valid = 1'b1;
                    n.rx_data = n.rx_sh;
                    n.rx_sh = 16'h0000;
                    load = 1'b1;
                    n.drive = !clock_phase_bit || half_fmt;
                end else if (half_fmt) begin
                    n.pend = 1'b1;
                    if (enable && tx_valid) begin
                        load = 1'b1;
                        n.st = SSF_SETUP;
                    end else begin
                        n.st = SSF_TAIL;
                    end
                end else begin
                    n.rx_valid = 1'b1;
                    n.rx_data = n.rx_sh;
                    n.rx_sh = 16'h0000;
                    if (clock_phase_bit && enable && tx_valid) begin
                        load = 1'b1;
                    end else begin
                        n.st = SSF_TAIL;
                    end
                end
            end
        end

        // a slave frame ends when the master lifts select; disabling aborts a frame
        if ((r.st != SSF_IDLE) && (!enable || (!is_master && fss_s))) begin
            n.st = SSF_IDLE;
            n.fss = 1'b1;
            n.drive = 1'b0;
            n.pend = 1'b0;
            n.div = 8'h00;
        end

        if (load) begin
            if (!tx_valid) begin
                n.tx_sh = 16'h0000;
            end else if (half_fmt) begin
                n.tx_sh = {tx_data[7:0], 8'h00};
            end else begin
                n.tx_sh = align_word(tx_data, nbits);
            end
        end
        n.sout = n.drive && n.tx_sh[15];
        // a word loaded on a phase 1 capture edge goes out one system clock later, keeping the peer's hold time
        if (edge_now && role[0] && load && spi_fmt && clock_phase_bit) begin
            n.sout = r.sout;
        end
        tx_ready = load && tx_valid;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            r <= RST;
        end else if (ce) begin
            r <= n;
        end
    end

    assign rx_valid = r.rx_valid;
    assign rx_data = r.rx_data;
    assign busy = (r.st != SSF_IDLE);
    assign port_serial_clock_out = r.sclk;
    assign port_serial_clock_oe = is_master;
    assign frame_select_line_out = r.fss;
    assign frame_select_line_oe = is_master;
    // slave output only while selected, so several slaves may share the line
    assign serial_out_line = r.sout;
    assign serial_out_line_oe = is_master ? enable : (r.st != SSF_IDLE);
endmodule

// ### hdl/ssf_consts.svh
// constants for the synchronous serial frame sequencer
// How it works
// - polarity 0 phase 1 idle: clock low, select high, output low; master drives clock
// - phase 1: select falls, half period later data and first clock edge
// - polarity 0 phase 1: sample on falling edges, change on rising edges
// - single word: select rises one full clock period after last capture
// - phase 1 back-to-back words keep select low until the last bit
// - polarity 1 idle: clock high, select high, output low
// - phase 0: slave drives at once, master data half later, edge half later
// - phase 0 continuous: master pulses select high between words
// - polarity 1 phase 1: first edge falls, sample rising, change falling
// - half-duplex frame starts with an 8-bit control word, nothing received meanwhile
// - half-duplex idle: clock low, select high, output low
// - select falling loads the control byte and puts its top bit out
// - half-duplex select stays low all frame; receive line idle during control
// - peer latches control on rising, drives reply on falling; we latch on rising
// - single half-duplex frame: select rises one period after last reply bit, word stored
// - continuous half-duplex: next control follows, word stored on following falling edge
// - half-duplex slave samples first bit on first rising edge after select falls
// - polarity sets idle clock level; phase 0 samples first edge, phase 1 second
// - words are 4 to 16 bits, sent most significant bit first
// - format codes: 00 spi-style, 10 half-duplex; 01 pulsed and 11 reserved never start a frame
`ifndef SSF_CONSTS_SVH
`define SSF_CONSTS_SVH
`define SSF_WORD_W 16
`define SSF_FMT_SPI 2'b00
`define SSF_FMT_PULSE 2'b01
`define SSF_FMT_HALF 2'b10
`define SSF_SIZE_MIN 4'h3
`define SSF_CTRL_EDGES 6'h10
`define SSF_REPLY_BASE 6'h11
`define SSF_HALF_CYCLES 8'h04
`define SSF_TAIL_LAST 6'h01
`endif

// ### hdl/ssf_pkg.sv
// types of the synchronous serial frame sequencer
package ssf_pkg;
    typedef enum logic [1:0] {
        SSF_IDLE = 2'b00,
        SSF_SETUP = 2'b01,
        SSF_XFER = 2'b10,
        SSF_TAIL = 2'b11
    } ssf_state_type;

    typedef struct packed {
        ssf_state_type st;
        logic [7:0] div;
        logic sclk;
        logic fss;
        logic drive;
        logic sout;
        logic [5:0] kcnt;
        logic [15:0] tx_sh;
        logic [15:0] rx_sh;
        logic pend;
        logic sclk_prev;
        logic rx_valid;
        logic [15:0] rx_data;
    } ssf_regs_type;
endpackage

// ### hdl/ssf_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module ssf_sync #(
    parameter int W = 3
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [1:0][W-1:0] stage_r;
    logic [1:0][W-1:0] stage_nxt;

    // the first stage feeds only the second
    always_comb begin
        stage_nxt = {stage_r[0], d_in};
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stage_r <= '0;
        end else if (ce) begin
            stage_r <= stage_nxt;
        end
    end

    assign q_out = stage_r[1];
endmodule

// ### tb/ssf_port_assertions.sv
// checker of the frame sequencer port timing
`timescale 1ns/10ps
`include "ssf_consts.svh"
module ssf_port_assertions #(
    parameter logic [7:0] HALF_CYCLES = 8'h04
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic is_master,
    input wire logic clock_polarity_bit,
    input wire logic clock_phase_bit,
    input wire logic [1:0] frame_format_field,
    input wire logic [3:0] word_size_field,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic [15:0] rx_data,
    input wire logic busy,
    input wire logic port_serial_clock_out,
    input wire logic port_serial_clock_oe,
    input wire logic frame_select_line_out,
    input wire logic frame_select_line_oe,
    input wire logic serial_out_line,
    input wire logic serial_out_line_oe
);
    localparam int H = int'(HALF_CYCLES);
    localparam int H2 = 2 * H;
    logic [7:0] edge_cnt;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // clock edges seen inside one low stretch of select
    always_ff @(posedge sys_clk) begin
        if (!rst_n || frame_select_line_out)
            edge_cnt <= 8'h0;
        else if (port_serial_clock_out != $past(port_serial_clock_out))
            edge_cnt <= edge_cnt + 8'h1;
    end
    property p_idle_lines;
        !busy && !$past(busy) |-> frame_select_line_out && !serial_out_line;
    endproperty
    a_idle_lines: assert property (p_idle_lines) else $error("select or data active in idle");
    property p_idle_clk;
        is_master && !busy && !$past(busy) && $past(rst_n) && $stable(is_master) && $stable(clock_polarity_bit)
            && $stable(frame_format_field) |-> port_serial_clock_out
            == (clock_polarity_bit && frame_format_field != `SSF_FMT_HALF);
    endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("wrong idle clock level");
    property p_pads;
        port_serial_clock_oe == is_master && frame_select_line_oe == is_master
            && (is_master ? serial_out_line_oe == enable : serial_out_line_oe == busy);
    endproperty
    a_pads: assert property (p_pads) else $error("pad enable wrong");
    property p_start;
        is_master && tx_ready |=> !frame_select_line_out;
    endproperty
    a_start: assert property (p_start) else $error("select not low after load");
    property p_lead_ph1;
        is_master && $fell(frame_select_line_out) && (clock_phase_bit || frame_format_field == `SSF_FMT_HALF)
            |-> $stable(port_serial_clock_out) ##H $changed(port_serial_clock_out);
    endproperty
    a_lead_ph1: assert property (p_lead_ph1) else $error("first edge not half period after select");
    property p_lead_ph0;
        is_master && $fell(frame_select_line_out) && frame_format_field == `SSF_FMT_SPI && !clock_phase_bit
            |-> $stable(port_serial_clock_out) ##H2 $changed(port_serial_clock_out);
    endproperty
    a_lead_ph0: assert property (p_lead_ph0) else $error("first edge not full period after select");
    property p_rx_clear;
        rx_valid |-> (rx_data >> ({1'b0, word_size_field} + 5'h1)) == 16'h0;
    endproperty
    a_rx_clear: assert property (p_rx_clear) else $error("received word not right-justified");
    property p_edges;
        is_master && frame_format_field == `SSF_FMT_SPI && $rose(frame_select_line_out) |-> edge_cnt != 8'h0
            && edge_cnt % (8'h2 * ({4'h0, word_size_field} + 8'h1)) == 8'h0;
    endproperty
    a_edges: assert property (p_edges) else $error("clock edge count per frame wrong");
    c_half: cover property (rx_valid && frame_format_field == `SSF_FMT_HALF);
    c_slave: cover property (!is_master && tx_ready);
    c_cont: cover property (edge_cnt > 8'h20);
endmodule
bind ssf_port ssf_port_assertions #(.HALF_CYCLES(HALF_CYCLES)) chk_u (.*);

// ### tb/ssf_peer.sv
// behavioural off-chip serial peer for the frame sequencer
`timescale 1ns/10ps
module ssf_peer (
    input wire logic sclk,
    input wire logic fss,
    input wire logic mosi,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic half,
    input wire logic [4:0] n,
    input wire logic [15:0] reply,
    output logic miso,
    output logic [15:0] got
);
    int idx = 0;
    int cnt = 0;
    initial miso = 1'b0;
    initial got = 16'h0;
    always @(negedge fss) begin
        cnt = 0;
        idx = n - 1;
        if (!cpha && !half) begin
            miso = reply[idx];
            idx--;
        end
    end
    // released line flips so a stale bit never passes for data
    always @(posedge fss)
        miso = ~miso;
    always @(sclk)
        if (!fss && half) begin
            if (sclk) begin
                cnt++;
                if (cnt <= 8)
                    got = {got[14:0], mosi};
                if (cnt == 9 + n) begin
                    cnt = 0;
                    idx = n - 1;
                end
            end else if (cnt >= 9 && idx >= 0) begin
                miso = reply[idx];
                idx--;
            end
        end else if (!fss) begin
            if ((sclk !== cpol) ^ cpha) begin
                got = {got[14:0], mosi};
                cnt++;
                if (cnt == n) begin
                    cnt = 0;
                    idx = n - 1;
                end
            end else if (idx >= 0) begin
                miso = reply[idx];
                idx--;
            end
        end
endmodule

// ### tb/sync_serial_frame_formats_test.sv
// self-checking bench of the frame sequencer
`timescale 1ns/10ps
module sync_serial_frame_formats_test;
    logic sys_clk = 1'b0;
    logic rst_n, ce, enable, is_master, clock_polarity_bit, clock_phase_bit, tx_valid, tx_ready, rx_valid, busy;
    logic [1:0] frame_format_field;
    logic [3:0] word_size_field;
    logic [15:0] tx_data, rx_data, peer_reply, peer_got;
    logic port_serial_clock_out, port_serial_clock_oe, frame_select_line_out, frame_select_line_oe;
    logic serial_out_line, serial_out_line_oe, peer_miso, m_clk, m_fss, m_mosi;
    wire port_serial_clock_in = port_serial_clock_oe ? port_serial_clock_out : m_clk;
    wire frame_select_line_in = frame_select_line_oe ? frame_select_line_out : m_fss;
    wire serial_in_line = is_master ? peer_miso : m_mosi;
    logic [15:0] txq[$];
    logic [15:0] expq[$];
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    int seed = 55324;
    ssf_port #(.HALF_CYCLES(8'h04)) dut_u (.*);
    ssf_peer peer_u (.sclk(port_serial_clock_in), .fss(frame_select_line_in), .mosi(serial_out_line),
        .cpol(clock_polarity_bit), .cpha(clock_phase_bit), .half(frame_format_field == 2'b10),
        .n({1'b0, word_size_field} + 5'h1), .reply(peer_reply), .miso(peer_miso), .got(peer_got));
    always #5 sys_clk = ~sys_clk;
    task check(input logic [15:0] seen, input logic [15:0] want);
        checks_done++;
        if (seen !== want) begin
            error_cnt++;
            $display("BAD %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task stop_test;
        if (error_cnt == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // transmit queue behaves as the fifo bottom entry; also the hang limit
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            stop_test();
        end
        if (tx_ready === 1'b1 && txq.size() > 0)
            void'(txq.pop_front());
        tx_valid <= (txq.size() > 0);
        tx_data <= (txq.size() > 0) ? txq[0] : 16'h0;
    end
    always @(posedge sys_clk)
        if (rx_valid === 1'b1)
            check(rx_data, (expq.size() > 0) ? expq.pop_front() : 16'hxxxx);
    task run(input int words);
        logic [15:0] d, mask;
        @(posedge sys_clk);
        word_size_field <= 4'h3 + 4'(($random(seed) & 32'h7fff) % 13);
        peer_reply <= 16'($random(seed));
        @(posedge sys_clk);
        mask = 16'hffff >> (4'hf - word_size_field);
        for (int k = 0; k < words; k++) begin
            d = 16'($random(seed));
            txq.push_back(d);
            expq.push_back(peer_reply & mask);
        end
        do begin
            @(posedge sys_clk);
            #1;
        end while (txq.size() > 0 || busy !== 1'b0);
        repeat (4) @(posedge sys_clk);
        if (frame_format_field == 2'b10)
            mask = 16'h00ff;
        check(peer_got & mask, d & mask);
    endtask
    // link clock is free of the system clock phase, 125 ns period
    task slave_word(input logic [7:0] w);
        logic [7:0] seen;
        expq.push_back({8'h0, w});
        #253 m_fss = 1'b0;
        #250;
        for (int i = 7; i >= 0; i--) begin
            m_clk = 1'b1;
            m_mosi = w[i];
            #62.5 m_clk = 1'b0;
            seen[i] = serial_out_line;
            #62.5;
        end
        #125 m_fss = 1'b1;
        m_mosi = ~m_mosi;
        check({8'h0, seen}, 16'h00c3);
        repeat (20) @(posedge sys_clk);
    endtask
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        enable = 1'b1;
        is_master = 1'b1;
        clock_polarity_bit = 1'b0;
        clock_phase_bit = 1'b0;
        frame_format_field = 2'b00;
        word_size_field = 4'h7;
        tx_valid = 1'b0;
        tx_data = 16'h0;
        peer_reply = 16'h0;
        m_clk = 1'b0;
        m_fss = 1'b1;
        m_mosi = 1'b0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int m = 0; m < 16; m++) begin
            @(posedge sys_clk);
            clock_polarity_bit <= m[0];
            clock_phase_bit <= m[1];
            frame_format_field <= m[2] ? 2'b10 : 2'b00;
            run(1 + m[3]);
        end
        @(posedge sys_clk);
        is_master <= 1'b0;
        clock_polarity_bit <= 1'b0;
        clock_phase_bit <= 1'b1;
        frame_format_field <= 2'b00;
        word_size_field <= 4'h7;
        txq.push_back(16'h00c3);
        slave_word(8'h5a);
        @(posedge sys_clk);
        is_master <= 1'b1;
        for (int r = 0; r < 3; r++) begin
            @(posedge sys_clk);
            frame_format_field <= (r == 2) ? 2'b00 : {r[0], 1'b1};
            word_size_field <= (r == 2) ? 4'h2 : 4'h7;
            txq.push_back(16'h00a5);
            repeat (40) @(posedge sys_clk);
            check({15'h0, busy}, 16'h0);
            check(16'(txq.size()), 16'h1);
            txq.delete();
        end
        check(16'(expq.size()), 16'h0);
        stop_test();
    end
endmodule
